// ### hdl/swcg_bank.sv
// supply-warning flag register and peripheral bus-clock gate registers on an Avalon-MM slave
// Function
// R01 - flag sets on low supply, including after reset
// R02 - flag at bit 7, sticky
// R03 - write 1 bit 6 clears unless still low
// R04 - bit 3 enables interrupt while flag set
// R05 - gate A bit 7 modulo timer clock
// R06 - gate A bit 5 timer/PWM clock
// R07 - gate A bit 4 converter clock
// R08 - gate A bit 0 serial clock
// R09 - gate B bit 6 flash register clock
// R10 - gate B bit 5 external interrupt clock
// R11 - gate B bit 4 keyboard interrupt clock
// R12 - gate B bit 3 all comparators clock
// R13 - gate B bit 2 only counter bus clock
// R14 - software disables peripheral before gating off
// R15 - software reprograms peripheral after gating on
// R16 - unimplemented bits read zero, ignore writes
// R17 - gates switch clocks without glitches
`timescale 1ns/1ns
`default_nettype none
`include "swcg_defs.svh"
module swcg_bank (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic supply_low,
    input wire logic ext_ref_clock,
    input wire logic low_power_osc_clock,
    output logic modulo_timer_clk,
    output logic timer_pwm_unit_clk,
    output logic adc_clk,
    output logic serial_comm_iface_clk,
    output logic flash_reg_gate_clk,
    output logic ext_irq_unit_clk,
    output logic keyboard_interrupt_unit_clk,
    output logic analog_comparator_clk,
    output logic rtc_bus_clk,
    output logic rtc_ext_ref_clock,
    output logic rtc_low_power_osc_clock,
    output logic supply_warn_irq,
    output logic irq
);
    // supply_low comes from the analog trip comparator, outside this clock domain
    logic low_s1_q;
    logic low_s2_q;
    logic low_s1_d;
    logic low_s2_d;

    always_comb begin
        low_s1_d = supply_low;
        low_s2_d = low_s1_q;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_s1_q <= 1'b0;
            low_s2_q <= 1'b0;
        end else begin
            low_s1_q <= low_s1_d;
            low_s2_q <= low_s2_d;
        end
    end

    // bus handshake: every access answers one cycle after it is presented
    swcg_pkg::swcg_bus_state_t bus_state_q;
    swcg_pkg::swcg_bus_state_t bus_state_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] resp_q;
    logic [1:0] resp_d;
    logic access;
    logic wr_take;
    logic rd_take;

    assign access = avs_read | avs_write;
    assign wr_take = avs_write && (bus_state_q == swcg_pkg::SWCG_BUS_ACK);
    assign rd_take = avs_read && (bus_state_q == swcg_pkg::SWCG_BUS_ACK);

    function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] off);
        addr_hit = (addr == off);
    endfunction : addr_hit

    function automatic logic addr_mapped(input logic [3:0] addr);
        addr_mapped = addr_hit(addr, `SWCG_OFF_WARN) || addr_hit(addr, `SWCG_OFF_GATE_A)
            || addr_hit(addr, `SWCG_OFF_GATE_B) || addr_hit(addr, `SWCG_OFF_IRQ_STAT);
    endfunction : addr_mapped

    logic lane0_wr;
    assign lane0_wr = wr_take && avs_byteenable[0];

    // register state
    logic flag_q;
    logic flag_d;
    logic warn_ie_q;
    logic warn_ie_d;
    logic [7:0] gate_a_q;
    logic [7:0] gate_a_d;
    logic [7:0] gate_b_q;
    logic [7:0] gate_b_d;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_stat_d;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_mask_d;
    logic [7:0] warn_read;
    logic flag_rise;
    logic flag_prev_q;
    logic flag_prev_d;
    logic bad_access;

    assign warn_read = {flag_q, 3'h0, warn_ie_q, 3'h0}; // see R02, R16
    assign flag_rise = flag_q & ~flag_prev_q;
    assign bad_access = wr_take && !addr_mapped(avs_address);

    always_comb begin
        bus_state_d = swcg_pkg::SWCG_BUS_IDLE;
        if (access && bus_state_q == swcg_pkg::SWCG_BUS_IDLE) begin
            bus_state_d = swcg_pkg::SWCG_BUS_ACK;
        end
        rdata_d = rdata_q;
        resp_d = resp_q;
        if (access && bus_state_q == swcg_pkg::SWCG_BUS_IDLE) begin
            resp_d = addr_mapped(avs_address) ? 2'h0 : 2'h3;
            rdata_d = 32'h0;
            if (avs_read) begin
                unique case (avs_address)
                    `SWCG_OFF_WARN: rdata_d = {24'h0, warn_read};
                    `SWCG_OFF_GATE_A: rdata_d = {24'h0, gate_a_q & `SWCG_MASK_GATE_A}; // see R16
                    `SWCG_OFF_GATE_B: rdata_d = {24'h0, gate_b_q & `SWCG_MASK_GATE_B}; // see R16
                    `SWCG_OFF_IRQ_STAT: rdata_d = {16'h0, irq_mask_q, irq_stat_q};
                    default: rdata_d = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_state_q <= swcg_pkg::SWCG_BUS_IDLE;
            rdata_q <= 32'h0;
            resp_q <= 2'h0;
        end else begin
            bus_state_q <= bus_state_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    assign avs_waitrequest = access && (bus_state_q != swcg_pkg::SWCG_BUS_ACK);
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

    // supply-warning flag: condition holds it set, acknowledge only clears when supply is good
    always_comb begin
        flag_d = flag_q;
        warn_ie_d = warn_ie_q;
        if (lane0_wr && addr_hit(avs_address, `SWCG_OFF_WARN)) begin
            warn_ie_d = avs_writedata[`SWCG_BIT_WARN_IRQ_EN];
            if (avs_writedata[`SWCG_BIT_WARN_CLEAR]) begin
                flag_d = 1'b0; // see R03
            end
        end
        // setting wins over the acknowledge, also covers a supply already low at reset release
        if (low_s2_q) begin
            flag_d = 1'b1; // see R01, R03
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
            warn_ie_q <= 1'b0;
        end else begin
            flag_q <= flag_d; // see R02
            warn_ie_q <= warn_ie_d;
        end
    end

    assign supply_warn_irq = flag_q & warn_ie_q; // see R04

    // gate registers reset enabled so peripherals run until software trims them
    always_comb begin
        gate_a_d = gate_a_q;
        gate_b_d = gate_b_q;
        if (lane0_wr && addr_hit(avs_address, `SWCG_OFF_GATE_A)) begin
            gate_a_d = avs_writedata[7:0] & `SWCG_MASK_GATE_A; // see R16
        end
        if (lane0_wr && addr_hit(avs_address, `SWCG_OFF_GATE_B)) begin
            gate_b_d = avs_writedata[7:0] & `SWCG_MASK_GATE_B; // see R16
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_a_q <= `SWCG_RST_GATE_A & `SWCG_MASK_GATE_A;
            gate_b_q <= `SWCG_RST_GATE_B & `SWCG_MASK_GATE_B;
        end else begin
            gate_a_q <= gate_a_d;
            gate_b_q <= gate_b_d;
        end
    end

    // sticky interrupt status: bit 0 warning rise, bit 1 write to unmapped offset
    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (lane0_wr && addr_hit(avs_address, `SWCG_OFF_IRQ_STAT)) begin
            irq_stat_d = irq_stat_q & ~avs_writedata[7:0];
        end
        if (wr_take && avs_byteenable[1] && addr_hit(avs_address, `SWCG_OFF_IRQ_STAT)) begin
            irq_mask_d = avs_writedata[15:8] & `SWCG_MASK_IRQ;
        end
        if (flag_rise) begin
            irq_stat_d[`SWCG_IRQ_BIT_WARN] = 1'b1;
        end
        if (bad_access) begin
            irq_stat_d[`SWCG_IRQ_BIT_GATE_ERR] = 1'b1;
        end
        flag_prev_d = flag_q;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_q <= 8'h00;
            irq_mask_q <= 8'h00;
            flag_prev_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            flag_prev_q <= flag_prev_d;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // gate enables in a fixed order, one glitch-free gate each
    logic [`SWCG_NUM_GATES-1:0] gate_en;
    logic [`SWCG_NUM_GATES-1:0] gate_clk;

    assign gate_en = {
        gate_a_q[`SWCG_BIT_MODULO_TIMER], // see R05
        gate_a_q[`SWCG_BIT_TIMER_PWM], // see R06
        gate_a_q[`SWCG_BIT_ADC], // see R07
        gate_a_q[`SWCG_BIT_SERIAL], // see R08
        gate_b_q[`SWCG_BIT_FLASH_REG], // see R09
        gate_b_q[`SWCG_BIT_EXT_IRQ], // see R10
        gate_b_q[`SWCG_BIT_KEYBOARD], // see R11
        gate_b_q[`SWCG_BIT_COMPARATOR], // see R12
        gate_b_q[`SWCG_BIT_RTC] // see R13
    };

    genvar gi;
    generate
        for (gi = 0; gi < `SWCG_NUM_GATES; gi++) begin : g_gate
            swcg_clock_gate swcg_clock_gate_i (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .enable(gate_en[gi]),
                .gated_clk(gate_clk[gi])
            );
        end
    endgenerate

    assign modulo_timer_clk = gate_clk[8];
    assign timer_pwm_unit_clk = gate_clk[7];
    assign adc_clk = gate_clk[6];
    assign serial_comm_iface_clk = gate_clk[5];
    assign flash_reg_gate_clk = gate_clk[4];
    assign ext_irq_unit_clk = gate_clk[3];
    assign keyboard_interrupt_unit_clk = gate_clk[2];
    assign analog_comparator_clk = gate_clk[1];
    assign rtc_bus_clk = gate_clk[0];
    // the counter's own reference clocks bypass the gate entirely
    assign rtc_ext_ref_clock = ext_ref_clock; // see R13
    assign rtc_low_power_osc_clock = low_power_osc_clock; // see R13

    // assertions
    a_flag_sets_low: assert property (@(posedge core_clk) disable iff (!reset_n) // see R01
        low_s2_q |=> flag_q) else $error("flag not set on low supply");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n) // see R02
        flag_q && !(lane0_wr && addr_hit(avs_address, `SWCG_OFF_WARN)) |=> flag_q)
        else $error("flag dropped without acknowledge");
    a_ack_blocked_low: assert property (@(posedge core_clk) disable iff (!reset_n) // see R03
        low_s2_q && lane0_wr && addr_hit(avs_address, `SWCG_OFF_WARN) |=> flag_q)
        else $error("acknowledge cleared flag while supply low");
    a_ack_clears: assert property (@(posedge core_clk) disable iff (!reset_n) // see R03
        !low_s2_q && lane0_wr && addr_hit(avs_address, `SWCG_OFF_WARN)
        && avs_writedata[`SWCG_BIT_WARN_CLEAR] |=> !flag_q)
        else $error("acknowledge did not clear flag");
    a_warn_irq_tie: assert property (@(posedge core_clk) disable iff (!reset_n) // see R04
        supply_warn_irq == (flag_q && warn_ie_q)) else $error("warning request wrong");
    a_gate_a_write: assert property (@(posedge core_clk) disable iff (!reset_n) // see R05, R06, R07, R08, R16
        lane0_wr && addr_hit(avs_address, `SWCG_OFF_GATE_A)
        |=> gate_a_q == ($past(avs_writedata[7:0]) & `SWCG_MASK_GATE_A))
        else $error("gate A not written");
    a_gate_b_write: assert property (@(posedge core_clk) disable iff (!reset_n) // see R09, R10, R11, R12, R13, R16
        lane0_wr && addr_hit(avs_address, `SWCG_OFF_GATE_B)
        |=> gate_b_q == ($past(avs_writedata[7:0]) & `SWCG_MASK_GATE_B))
        else $error("gate B not written");
    // narrow writes that skip lane 0 must leave both gate registers and the warning enable alone
    a_lane0_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_take && !avs_byteenable[0] |=> $stable(gate_a_q) && $stable(gate_b_q) && $stable(warn_ie_q))
        else $error("write without lane 0 changed a register");
    // checked on the bus itself so a stray bit in the read mux is caught too
    a_warn_rsvd_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // see R16
        avs_read && !avs_waitrequest && addr_hit(avs_address, `SWCG_OFF_WARN)
        |-> avs_readdata == {24'h0, avs_readdata[7:0] & `SWCG_MASK_WARN})
        else $error("reserved bits of warning register read nonzero");
    // a warning rise that meets a clearing write must still be recorded
    a_stat_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
        flag_rise |=> irq_stat_q[`SWCG_IRQ_BIT_WARN]) else $error("warning rise not recorded in status");
    a_irq_needs_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq_mask_q == 8'h00 |-> !irq) else $error("interrupt raised with all sources masked");

    // a request is first seen with waitrequest high and answered in the very next cycle
    sequence s_bus_req;
        access && avs_waitrequest;
    endsequence

    sequence s_bus_answer;
        !avs_waitrequest;
    endsequence

    property p_one_wait;
        @(posedge core_clk) disable iff (!reset_n)
        s_bus_req |=> s_bus_answer;
    endproperty

    a_bus_one_wait: assert property (p_one_wait) else $error("access not answered after one wait");
    a_bus_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
        access && !avs_waitrequest |=> avs_waitrequest || !access)
        else $error("bus answered twice");
    a_resp_unmapped: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_bus_req ##0 !addr_mapped(avs_address) |=> avs_response == 2'h3)
        else $error("unmapped access answered okay");
endmodule : swcg_bank
`default_nettype wire

// ### hdl/swcg_defs.svh
// register offsets, field positions, masks and reset values of the supply-warning and clock-gate bank
`ifndef SWCG_DEFS_SVH
`define SWCG_DEFS_SVH

`define SWCG_OFF_WARN 4'h0
`define SWCG_OFF_GATE_A 4'h4
`define SWCG_OFF_GATE_B 4'h8
`define SWCG_OFF_IRQ_STAT 4'hC

`define SWCG_BIT_WARN_FLAG 7
`define SWCG_BIT_WARN_CLEAR 6
`define SWCG_BIT_WARN_IRQ_EN 3

`define SWCG_BIT_MODULO_TIMER 7
`define SWCG_BIT_TIMER_PWM 5
`define SWCG_BIT_ADC 4
`define SWCG_BIT_SERIAL 0

`define SWCG_BIT_FLASH_REG 6
`define SWCG_BIT_EXT_IRQ 5
`define SWCG_BIT_KEYBOARD 4
`define SWCG_BIT_COMPARATOR 3
`define SWCG_BIT_RTC 2

`define SWCG_MASK_WARN 8'h88
`define SWCG_MASK_GATE_A 8'hB1
`define SWCG_MASK_GATE_B 8'h7C

`define SWCG_RST_WARN 8'h00
`define SWCG_RST_GATE_A 8'hFF
`define SWCG_RST_GATE_B 8'hFF

`define SWCG_IRQ_BIT_WARN 0
`define SWCG_IRQ_BIT_GATE_ERR 1
`define SWCG_MASK_IRQ 8'h03

`define SWCG_NUM_GATES 9

`endif

// ### hdl/swcg_pkg.sv
// types shared by the supply-warning and clock-gate bank
package swcg_pkg;
    typedef enum logic [1:0] {
        SWCG_BUS_IDLE,
        SWCG_BUS_ACK
    } swcg_bus_state_t;
endpackage : swcg_pkg

// ### hdl/swcg_clock_gate.sv
// glitch-free clock gate with a falling-edge enable register for one peripheral bus clock
`timescale 1ns/1ns
`default_nettype none
module swcg_clock_gate (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic enable,
    output logic gated_clk
);
    logic en_q;
    logic en_d;

    // enable is retimed on the falling edge so it only changes while the clock is low
    always_comb begin
        en_d = enable;
    end

    always_ff @(negedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_d;
        end
    end

    assign gated_clk = core_clk & en_q; // see R17

    // the register only takes the enable on the falling edge, so at every rising edge they agree
    a_gate_tracks_en: assert property (@(posedge core_clk) disable iff (!reset_n) // see R17
        reset_n |-> en_q == enable) else $error("gate enable not settled before rising edge");
endmodule : swcg_clock_gate
`default_nettype wire

// ### tb/swcg_bank_tb_top.sv
// self-checking bench for the supply-warning flag and clock-gate register bank
`timescale 1ns/1ns
`default_nettype none
module swcg_bank_tb_top;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic supply_low = 1'h0;
    logic ext_ref_clock = 1'h0;
    logic low_power_osc_clock = 1'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic modulo_timer_clk, timer_pwm_unit_clk, adc_clk, serial_comm_iface_clk, flash_reg_gate_clk;
    logic ext_irq_unit_clk, keyboard_interrupt_unit_clk, analog_comparator_clk, rtc_bus_clk;
    logic rtc_ext_ref_clock, rtc_low_power_osc_clock, supply_warn_irq, irq;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [3:0] bus_be = 4'hF;
    // gated clocks packed at their register bit positions
    wire logic [7:0] clk_a = {modulo_timer_clk, 1'h0, timer_pwm_unit_clk, adc_clk, 3'h0, serial_comm_iface_clk};
    wire logic [7:0] clk_b = {1'h0, flash_reg_gate_clk, ext_irq_unit_clk, keyboard_interrupt_unit_clk,
        analog_comparator_clk, rtc_bus_clk, 2'h0};

    swcg_bank swcg_bank_i (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .supply_low(supply_low), .ext_ref_clock(ext_ref_clock),
        .low_power_osc_clock(low_power_osc_clock), .modulo_timer_clk(modulo_timer_clk),
        .timer_pwm_unit_clk(timer_pwm_unit_clk), .adc_clk(adc_clk), .serial_comm_iface_clk(serial_comm_iface_clk),
        .flash_reg_gate_clk(flash_reg_gate_clk), .ext_irq_unit_clk(ext_irq_unit_clk),
        .keyboard_interrupt_unit_clk(keyboard_interrupt_unit_clk), .analog_comparator_clk(analog_comparator_clk),
        .rtc_bus_clk(rtc_bus_clk), .rtc_ext_ref_clock(rtc_ext_ref_clock),
        .rtc_low_power_osc_clock(rtc_low_power_osc_clock), .supply_warn_irq(supply_warn_irq), .irq(irq));

    always #10 core_clk = ~core_clk;

    task automatic test_done();
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // generous ceiling: the whole sequence needs well under 1000 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // entered just after a rising edge; held until waitrequest is seen low at a rising edge,
    // one idle clock after the release so the next call never reassigns in the same step
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= we;
        avs_read <= ~we;
        avs_writedata <= d;
        avs_byteenable <= bus_be;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'h0) begin
            @(posedge core_clk);
        end
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge core_clk);
    endtask : bus

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] resp);
        bus(1'h0, a, 32'h0);
        chk(rd, exp);
        chk({30'h0, rs}, {30'h0, resp});
    endtask : rdchk

    task automatic t_reset_vals();
        rdchk(4'h0, 32'h0, 2'h0);
        rdchk(4'h4, 32'hB1, 2'h0);
        rdchk(4'h8, 32'h7C, 2'h0);
        rdchk(4'hC, 32'h0, 2'h0);
    endtask : t_reset_vals

    task automatic t_gates();
        logic [7:0] pat [4] = '{8'h00, 8'h5A, 8'hA5, 8'hFF};
        // nothing runs behind the gates here, so switching them needs no peripheral shutdown or reload
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, 4'h4, {24'h0, pat[i]});
            bus(1'h1, 4'h8, {24'h0, pat[i]});
            rdchk(4'h4, {24'h0, pat[i] & 8'hB1}, 2'h0);
            rdchk(4'h8, {24'h0, pat[i] & 8'h7C}, 2'h0);
            #1;
            chk({24'h0, clk_a}, {24'h0, pat[i] & 8'hB1});
            chk({24'h0, clk_b}, {24'h0, pat[i] & 8'h7C});
            @(negedge core_clk);
            #1;
            chk({24'h0, clk_a | clk_b}, 32'h0);
            @(posedge core_clk);
        end
        // a write that leaves lane 0 off must not touch the gate bits
        bus_be = 4'hE;
        bus(1'h1, 4'h4, 32'h0);
        bus_be = 4'hF;
        rdchk(4'h4, 32'hB1, 2'h0);
    endtask : t_gates

    task automatic t_warn();
        bus(1'h1, 4'h0, 32'hFF);
        rdchk(4'h0, 32'h08, 2'h0);
        supply_low <= 1'h1;
        repeat (4) @(posedge core_clk);
        rdchk(4'h0, 32'h88, 2'h0);
        chk({31'h0, supply_warn_irq}, 32'h1);
        bus(1'h1, 4'h0, 32'h48);
        rdchk(4'h0, 32'h88, 2'h0);
        supply_low <= 1'h0;
        repeat (4) @(posedge core_clk);
        rdchk(4'h0, 32'h88, 2'h0);
        bus(1'h1, 4'h0, 32'h48);
        rdchk(4'h0, 32'h08, 2'h0);
        chk({31'h0, supply_warn_irq}, 32'h0);
        bus(1'h1, 4'h0, 32'h00);
        supply_low <= 1'h1;
        repeat (4) @(posedge core_clk);
        supply_low <= 1'h0;
        repeat (4) @(posedge core_clk);
        rdchk(4'h0, 32'h80, 2'h0);
        chk({31'h0, supply_warn_irq}, 32'h0);
        bus(1'h1, 4'h0, 32'h40);
        rdchk(4'h0, 32'h00, 2'h0);
    endtask : t_warn

    task automatic t_status();
        rdchk(4'hC, 32'h01, 2'h0);
        bus(1'h1, 4'hC, 32'h0100);
        chk({31'h0, irq}, 32'h1);
        bus(1'h1, 4'hC, 32'h0101);
        chk({31'h0, irq}, 32'h0);
        bus(1'h1, 4'h6, 32'hFF);
        chk({30'h0, rs}, 32'h3);
        rdchk(4'hC, 32'h0102, 2'h0);
        bus(1'h1, 4'hC, 32'h0200);
        chk({31'h0, irq}, 32'h1);
        bus(1'h1, 4'hC, 32'h0202);
        chk({31'h0, irq}, 32'h0);
        rdchk(4'h2, 32'h0, 2'h3);
    endtask : t_status

    task automatic t_rtc_pass();
        bus(1'h1, 4'h8, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ext_ref_clock <= ~ext_ref_clock;
            low_power_osc_clock <= i[1];
            @(posedge core_clk);
            #1;
            chk({30'h0, rtc_ext_ref_clock, rtc_low_power_osc_clock}, {30'h0, ext_ref_clock, i[1]});
            chk({31'h0, rtc_bus_clk}, 32'h0);
            @(posedge core_clk);
        end
    endtask : t_rtc_pass

    // low supply already present when reset ends must still raise the flag
    task automatic t_reset_low();
        supply_low <= 1'h1;
        reset_n <= 1'h0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'h1;
        repeat (5) @(posedge core_clk);
        rdchk(4'h0, 32'h80, 2'h0);
        rdchk(4'h8, 32'h7C, 2'h0);
        supply_low <= 1'h0;
    endtask : t_reset_low

    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'h1;
        @(posedge core_clk);
        t_reset_vals();
        t_gates();
        t_warn();
        t_status();
        t_rtc_pass();
        t_reset_low();
        test_done();
    end
endmodule : swcg_bank_tb_top
`default_nettype wire
